// File: verilog/ouhs_host_select.sv
// host select glue of an eight channel uart: bus decode, resets, strap, interrupt levels
// assumes all pins are synchronous to clk_sys_i and the uart cores sit outside
`timescale 1ns/1ps

module ouhs_host_select
   import ouhs_pkg::*;
(
   input  wire logic                         clk_sys_i,
   input  wire logic                         reset_i,
   input  wire logic                         bus_sep_strobes_i,
   input  wire logic                         cs_n_i,
   input  wire logic                         read_strobe_n_i,
   input  wire logic                         write_strobe_n_i,
   input  wire logic [7:0]                   addr_i,
   input  wire logic [7:0]                   wr_data_i,
   input  wire logic                         infrared_start_strap_i,
   input  wire logic                         timer_ext_clock_in_i,
   input  wire logic                         sleep_wake_i,
   input  wire ouhs_modem_in_t  [7:0]        modem_in_i,
   input  wire ouhs_fifo_stat_t [7:0]        fifo_stat_i,
   output logic [7:0]                        rd_data_o,
   output logic                              rd_valid_o,
   output ouhs_modem_out_t [7:0]             modem_out_o,
   output logic [7:0]                        fifo_ctl_o [8],
   output logic [7:0]                        modem_ctl_o [8],
   output logic [7:0]                        hdx_ctl_o [8],
   output logic [7:0]                        tx_int_level_o,
   output logic [7:0]                        rx_int_level_o,
   output logic                              int_o
);

   // ==========================================================
   // strobe edges
   logic       cs_n_ff;
   logic       rd_n_ff;
   logic       wr_n_ff;
   logic       nxt_cs_n;
   logic       nxt_rd_n;
   logic       nxt_wr_n;
   logic       rd_ev;
   logic       wr_ev;

   // strobes idle high after reset so a low held through reset counts as an access on the first edge after release
   always_comb begin
      nxt_cs_n = cs_n_i;
      nxt_rd_n = read_strobe_n_i;
      nxt_wr_n = write_strobe_n_i;
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cs_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
      end else begin
         cs_n_ff <= nxt_cs_n;
         rd_n_ff <= nxt_rd_n;
         wr_n_ff <= nxt_wr_n;
      end
   end

   // separate mode: strobe falls while selected; single mode: select falls, write pin is r/w
   always_comb begin
      if (bus_sep_strobes_i) begin
         rd_ev = ~cs_n_i & rd_n_ff & ~read_strobe_n_i;
         wr_ev = ~cs_n_i & wr_n_ff & ~write_strobe_n_i;
      end else begin
         rd_ev = cs_n_ff & ~cs_n_i & write_strobe_n_i;
         wr_ev = cs_n_ff & ~cs_n_i & ~write_strobe_n_i;
      end
   end

   // ==========================================================
   // decode
   logic       cfg_space;
   logic [2:0] ch_sel;
   logic       cfg_wr;

   assign cfg_space = addr_i[OUHS_CFG_SPACE_BIT];
   assign ch_sel    = addr_i[OUHS_CH_SEL_MSB:OUHS_CH_SEL_LSB];
   assign cfg_wr    = wr_ev & cfg_space;

   // ==========================================================
   // configuration registers, timer, strap sequencing
   logic [7:0]  bcast_ff;
   logic [7:0]  tctl_ff;
   logic [15:0] tmr_ff;
   logic        tmr_flag_ff;
   logic        tck_ff;
   ouhs_init_t  init_ff;
   logic [7:0]  nxt_bcast;
   logic [7:0]  nxt_tctl;
   logic [15:0] nxt_tmr;
   logic        nxt_tmr_flag;
   logic        nxt_tck;
   ouhs_init_t  nxt_init;
   logic        tmr_tick;
   logic        tmr_wrap;
   logic        int3_rd;
   logic [7:0]  soft_rst;
   logic        strap_load;

   always_comb begin
      nxt_bcast    = bcast_ff;
      nxt_tctl     = tctl_ff;
      nxt_tmr      = tmr_ff;
      nxt_tmr_flag = tmr_flag_ff;
      nxt_tck      = timer_ext_clock_in_i;
      nxt_init     = init_ff;
      soft_rst     = 8'h00;
      strap_load   = 1'b0;
      // strap is caught on the first edge after reset release, never under reset
      case (init_ff)
         OUHS_INIT_STRAP: begin
            strap_load = 1'b1;
            nxt_init   = OUHS_INIT_RUN;
         end
         OUHS_INIT_RUN: begin
            nxt_init = OUHS_INIT_RUN;
         end
         default: begin
            nxt_init = OUHS_INIT_STRAP;
         end
      endcase
      if (cfg_wr && addr_i[6:0] == OUHS_CFG_BCAST_OFS) begin
         nxt_bcast = wr_data_i;
      end
      if (cfg_wr && addr_i[6:0] == OUHS_CFG_TCTL_OFS) begin
         nxt_tctl = wr_data_i;
      end
      if (cfg_wr && addr_i[6:0] == OUHS_CFG_RST_OFS) begin
         soft_rst = wr_data_i;
      end
      // external source counts rising edges of the sampled timer pin
      tmr_tick = tctl_ff[OUHS_TCTL_RUN] &
                 (tctl_ff[OUHS_TCTL_EXT] ? (timer_ext_clock_in_i & ~tck_ff) : 1'b1);
      tmr_wrap = tmr_tick & (tmr_ff == 16'hFFFF);
      if (tmr_tick) begin
         nxt_tmr = tmr_ff + 16'h0001;
      end
      if (cfg_wr && addr_i[6:0] == OUHS_CFG_TLO_OFS) begin
         nxt_tmr[7:0] = wr_data_i;
      end
      if (cfg_wr && addr_i[6:0] == OUHS_CFG_THI_OFS) begin
         nxt_tmr[15:8] = wr_data_i;
      end
      // reading the last source register clears the timer flag; a wrap in that cycle wins
      int3_rd = rd_ev & cfg_space & (addr_i[6:0] == OUHS_CFG_INT3_OFS);
      if (int3_rd) begin
         nxt_tmr_flag = 1'b0;
      end
      if (tmr_wrap) begin
         nxt_tmr_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         bcast_ff    <= OUHS_REG_RST_VAL;
         tctl_ff     <= OUHS_REG_RST_VAL;
         tmr_ff      <= OUHS_TMR_RST_VAL;
         tmr_flag_ff <= 1'b0;
         tck_ff      <= 1'b0;
         init_ff     <= OUHS_INIT_STRAP;
      end else begin
         bcast_ff    <= nxt_bcast;
         tctl_ff     <= nxt_tctl;
         tmr_ff      <= nxt_tmr;
         tmr_flag_ff <= nxt_tmr_flag;
         tck_ff      <= nxt_tck;
         init_ff     <= nxt_init;
      end
   end

   // ==========================================================
   // per channel registers, modem pins and interrupt levels
   logic [7:0] fcr_q [8];
   logic [7:0] mcr_q [8];
   logic [7:0] hdx_q [8];
   logic [7:0] msr_q [8];

   genvar ch;
   generate
      for (ch = 0; ch < OUHS_NUM_CH; ch++) begin : g_ch
         logic [7:0] fcr_ff;
         logic [7:0] mcr_ff;
         logic [7:0] hdx_ff;
         logic [7:0] nxt_fcr;
         logic [7:0] nxt_mcr;
         logic [7:0] nxt_hdx;
         logic       ch_wr;
         logic       fifo_on;
         logic       tx_lvl;

         // broadcast ignores a6..a4 so one write lands in every channel
         assign ch_wr = wr_ev & ~cfg_space &
                        (bcast_ff[OUHS_BCAST_EN] | (ch_sel == 3'(ch)));

         always_comb begin
            nxt_fcr = fcr_ff;
            nxt_mcr = mcr_ff;
            nxt_hdx = hdx_ff;
            if (ch_wr && addr_i[3:0] == OUHS_CH_FCR_OFS) begin
               nxt_fcr = wr_data_i;
            end
            if (ch_wr && addr_i[3:0] == OUHS_CH_MCR_OFS) begin
               nxt_mcr = wr_data_i;
            end
            if (ch_wr && addr_i[3:0] == OUHS_CH_HDX_OFS) begin
               nxt_hdx = wr_data_i;
            end
            // soft reset overrides a same-cycle write and reloads the strap
            if (soft_rst[ch]) begin
               nxt_fcr = OUHS_REG_RST_VAL;
               nxt_mcr = OUHS_REG_RST_VAL;
               nxt_hdx = OUHS_REG_RST_VAL;
            end
            if (soft_rst[ch] || strap_load) begin
               nxt_mcr[OUHS_MCR_IR] = infrared_start_strap_i;
            end
         end

         always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
               fcr_ff <= OUHS_REG_RST_VAL;
               mcr_ff <= OUHS_REG_RST_VAL;
               hdx_ff <= OUHS_REG_RST_VAL;
            end else begin
               fcr_ff <= nxt_fcr;
               mcr_ff <= nxt_mcr;
               hdx_ff <= nxt_hdx;
            end
         end

         // reset value of zero leaves both pins high, the inactive level
         assign modem_out_o[ch].request_to_send_n = ~mcr_ff[OUHS_MCR_RTS];
         assign modem_out_o[ch].terminal_ready_n  = ~mcr_ff[OUHS_MCR_DTR];
         assign msr_q[ch] = {4'h0,
                             ~modem_in_i[ch].carrier_detect_n,
                             ~modem_in_i[ch].ring_indicator_n,
                             ~modem_in_i[ch].set_ready_n,
                             ~modem_in_i[ch].clear_to_send_n};

         assign fifo_on = fcr_ff[OUHS_FCR_FIFO_EN];
         // half duplex keeps the level low only once the shifter has also drained
         assign tx_lvl  = fifo_stat_i[ch].tx_above_trig &
                          ~(hdx_ff[OUHS_HDX_EN] ? fifo_stat_i[ch].tx_all_empty
                                                : fifo_stat_i[ch].tx_fifo_empty);
         // levels with fifos off are left low: that mode is not defined here
         assign tx_int_level_o[ch] = fifo_on & tx_lvl;
         assign rx_int_level_o[ch] = fifo_on & ~fifo_stat_i[ch].rx_above_trig;

         assign fcr_q[ch]       = fcr_ff;
         assign mcr_q[ch]       = mcr_ff;
         assign hdx_q[ch]       = hdx_ff;
         assign fifo_ctl_o[ch]  = fcr_ff;
         assign modem_ctl_o[ch] = mcr_ff;
         assign hdx_ctl_o[ch]   = hdx_ff;
      end
   endgenerate

   assign int_o = |(tx_int_level_o | rx_int_level_o);

   // ==========================================================
   // read path
   logic [7:0] rd_data_ff;
   logic       rd_valid_ff;
   logic [7:0] nxt_rd_data;
   logic       nxt_rd_valid;
   logic [7:0] int3_val;

   assign int3_val = {6'h00, sleep_wake_i, tmr_flag_ff};

   always_comb begin
      nxt_rd_data  = rd_data_ff;
      nxt_rd_valid = rd_ev;
      if (rd_ev) begin
         nxt_rd_data = 8'h00;
         if (cfg_space) begin
            case (addr_i[6:0])
               OUHS_CFG_INT0_OFS:  nxt_rd_data = tx_int_level_o | rx_int_level_o;
               OUHS_CFG_INT1_OFS:  nxt_rd_data = tx_int_level_o;
               OUHS_CFG_INT2_OFS:  nxt_rd_data = rx_int_level_o;
               OUHS_CFG_INT3_OFS:  nxt_rd_data = int3_val;
               OUHS_CFG_TCTL_OFS:  nxt_rd_data = tctl_ff;
               OUHS_CFG_TLO_OFS:   nxt_rd_data = tmr_ff[7:0];
               OUHS_CFG_THI_OFS:   nxt_rd_data = tmr_ff[15:8];
               OUHS_CFG_BCAST_OFS: nxt_rd_data = bcast_ff;
               default:            nxt_rd_data = 8'h00;
            endcase
         end else begin
            case (addr_i[3:0])
               OUHS_CH_FCR_OFS: nxt_rd_data = fcr_q[ch_sel];
               OUHS_CH_MCR_OFS: nxt_rd_data = mcr_q[ch_sel];
               OUHS_CH_MSR_OFS: nxt_rd_data = msr_q[ch_sel];
               OUHS_CH_HDX_OFS: nxt_rd_data = hdx_q[ch_sel];
               default:         nxt_rd_data = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         rd_data_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign rd_data_o  = rd_data_ff;
   assign rd_valid_o = rd_valid_ff;

endmodule // ouhs_host_select

// File: verilog/ouhs_pkg.sv
// constants, layouts and carrier types for the octal uart host select glue
// assumes a single 40 mhz system clock and an 8-bit parallel host bus
package ouhs_pkg;
   // ==========================================================
   // sizes and clock
   localparam int          OUHS_NUM_CH        = 8;
   localparam int          OUHS_CLK_PERIOD_NS = 25;
   localparam int          OUHS_RST_MIN_NS    = 40;
   localparam int          OUHS_RST_MIN_CYC   =
      (OUHS_RST_MIN_NS + OUHS_CLK_PERIOD_NS - 1) / OUHS_CLK_PERIOD_NS;

   // ==========================================================
   // address decode
   localparam int          OUHS_CFG_SPACE_BIT = 7;
   localparam int          OUHS_CH_SEL_LSB    = 4;
   localparam int          OUHS_CH_SEL_MSB    = 6;

   // ==========================================================
   // channel register offsets (address bits 3:0)
   localparam logic [3:0]  OUHS_CH_FCR_OFS    = 4'h2;
   localparam logic [3:0]  OUHS_CH_MCR_OFS    = 4'h4;
   localparam logic [3:0]  OUHS_CH_MSR_OFS    = 4'h6;
   localparam logic [3:0]  OUHS_CH_HDX_OFS    = 4'h8;

   // ==========================================================
   // configuration register offsets (address bits 6:0)
   localparam logic [6:0]  OUHS_CFG_INT0_OFS  = 7'h00;
   localparam logic [6:0]  OUHS_CFG_INT1_OFS  = 7'h01;
   localparam logic [6:0]  OUHS_CFG_INT2_OFS  = 7'h02;
   localparam logic [6:0]  OUHS_CFG_INT3_OFS  = 7'h03;
   localparam logic [6:0]  OUHS_CFG_TCTL_OFS  = 7'h08;
   localparam logic [6:0]  OUHS_CFG_TLO_OFS   = 7'h09;
   localparam logic [6:0]  OUHS_CFG_THI_OFS   = 7'h0A;
   localparam logic [6:0]  OUHS_CFG_RST_OFS   = 7'h0B;
   localparam logic [6:0]  OUHS_CFG_BCAST_OFS = 7'h0C;

   // ==========================================================
   // field positions
   localparam int          OUHS_FCR_FIFO_EN   = 0;
   localparam int          OUHS_MCR_DTR       = 0;
   localparam int          OUHS_MCR_RTS       = 1;
   localparam int          OUHS_MCR_IR        = 6;
   localparam int          OUHS_HDX_EN        = 0;
   localparam int          OUHS_BCAST_EN      = 0;
   localparam int          OUHS_TCTL_RUN      = 0;
   localparam int          OUHS_TCTL_EXT      = 1;
   localparam int          OUHS_INT3_TMR      = 0;
   localparam int          OUHS_INT3_WAKE     = 1;

   // ==========================================================
   // reset values
   localparam logic [7:0]  OUHS_REG_RST_VAL   = 8'h00;
   localparam logic [15:0] OUHS_TMR_RST_VAL   = 16'h0000;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic clear_to_send_n;
      logic set_ready_n;
      logic carrier_detect_n;
      logic ring_indicator_n;
   } ouhs_modem_in_t;

   typedef struct packed {
      logic request_to_send_n;
      logic terminal_ready_n;
   } ouhs_modem_out_t;

   typedef struct packed {
      logic tx_above_trig;
      logic tx_fifo_empty;
      logic tx_all_empty;
      logic rx_above_trig;
   } ouhs_fifo_stat_t;

   typedef enum logic [1:0] {
      OUHS_INIT_STRAP = 2'b00,
      OUHS_INIT_RUN   = 2'b01
   } ouhs_init_t;
endpackage

// File: verification/ouhs_host_select_props.sv
// checker for the uart host select glue, bound to the top module ports
// assumes one clock domain and strobes idling high out of reset
`timescale 1ns/1ps
module ouhs_host_select_props
   import ouhs_pkg::*;
(
   input  wire logic                  clk_sys_i,
   input  wire logic                  reset_i,
   input  wire logic                  bus_sep_strobes_i,
   input  wire logic                  cs_n_i,
   input  wire logic                  read_strobe_n_i,
   input  wire logic                  write_strobe_n_i,
   input  wire logic [7:0]            addr_i,
   input  wire logic [7:0]            wr_data_i,
   input  wire logic                  infrared_start_strap_i,
   input  wire ouhs_fifo_stat_t [7:0] fifo_stat_i,
   input  wire logic                  rd_valid_o,
   input  wire ouhs_modem_out_t [7:0] modem_out_o,
   input  wire logic [7:0]            fifo_ctl_o [8],
   input  wire logic [7:0]            modem_ctl_o [8],
   input  wire logic [7:0]            hdx_ctl_o [8],
   input  wire logic [7:0]            tx_int_level_o,
   input  wire logic [7:0]            rx_int_level_o,
   input  wire logic                  int_o
);
   // ==========================================================
   // helper state: strobe history mirrors the glue's edge detect
   logic       wr_prev_ff, rd_prev_ff, cs_prev_ff, bcast_ff, nxt_bcast;
   logic [7:0] wd_ff, exp_tx, exp_rx, ir_vec;
   logic [2:0] ch_ff;
   logic       wr_take, rd_take, mcr_all;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   always_comb begin
      wr_take = !cs_n_i && !write_strobe_n_i
                && (bus_sep_strobes_i ? wr_prev_ff : cs_prev_ff);
      rd_take = !cs_n_i && (bus_sep_strobes_i ? (!read_strobe_n_i && rd_prev_ff)
                                              : (cs_prev_ff && write_strobe_n_i));
      nxt_bcast = (wr_take && addr_i == {1'b1, OUHS_CFG_BCAST_OFS}) ? wr_data_i[0] : bcast_ff;
      mcr_all = 1'b1;
      for (int k = 0; k < 8; k++) begin
         ir_vec[k] = modem_ctl_o[k][OUHS_MCR_IR];
         exp_tx[k] = fifo_ctl_o[k][0] & fifo_stat_i[k].tx_above_trig
                     & ~(hdx_ctl_o[k][0] ? fifo_stat_i[k].tx_all_empty
                                         : fifo_stat_i[k].tx_fifo_empty);
         exp_rx[k] = fifo_ctl_o[k][0] & ~fifo_stat_i[k].rx_above_trig;
         mcr_all   = mcr_all & (modem_ctl_o[k] == wd_ff);
      end
   end
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         wr_prev_ff <= 1'b1;
         rd_prev_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
         bcast_ff   <= 1'b0;
         wd_ff      <= 8'h00;
         ch_ff      <= 3'h0;
      end else begin
         wr_prev_ff <= write_strobe_n_i;
         rd_prev_ff <= read_strobe_n_i;
         cs_prev_ff <= cs_n_i;
         bcast_ff   <= nxt_bcast;
         wd_ff      <= wr_data_i;
         ch_ff      <= addr_i[6:4];
      end
   end
   // ==========================================================
   // properties
   sequence s_wr_mcr;
      wr_take && !addr_i[7] && addr_i[3:0] == OUHS_CH_MCR_OFS;
   endsequence
   property p_reset_state;
      $fell(reset_i) |-> modem_out_o == '1 && !int_o && !rd_valid_o;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs not at reset state");
   property p_strap;
      $fell(reset_i) |=> ir_vec == {8{infrared_start_strap_i}};
   endproperty
   a_strap: assert property (p_strap)
      else $error("strap not copied after reset");
   property p_soft;
      wr_take && addr_i == {1'b1, OUHS_CFG_RST_OFS} && wr_data_i[0]
      |=> modem_ctl_o[0] == {1'b0, infrared_start_strap_i, 6'h00};
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset missed channel 0");
   property p_chan;
      s_wr_mcr ##0 !bcast_ff |=> modem_ctl_o[ch_ff] == wd_ff;
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel write went astray");
   property p_bcast;
      s_wr_mcr ##0 bcast_ff |=> mcr_all;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast missed a channel");
   property p_cs;
      cs_n_i |=> $stable(modem_out_o) && !rd_valid_o;
   endproperty
   a_cs: assert property (p_cs)
      else $error("access without chip select");
   property p_rd;
      rd_take |-> ##[1:2] rd_valid_o;
   endproperty
   a_rd: assert property (p_rd)
      else $error("read not answered");
   property p_tx;
      tx_int_level_o == exp_tx && int_o == |(tx_int_level_o | rx_int_level_o);
   endproperty
   a_tx: assert property (p_tx)
      else $error("tx level wrong");
   property p_rx;
      rx_int_level_o == exp_rx;
   endproperty
   a_rx: assert property (p_rx)
      else $error("rx level wrong");
endmodule // ouhs_host_select_props

// File: verification/ouhs_host_model.sv
// host processor model on the 8-bit parallel bus of the glue
// assumes tasks are called from one bench thread
`timescale 1ns/1ps
module ouhs_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i,
   output logic            sep_o,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      data_o
);
   initial begin
      sep_o  = 1'b1;
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 8'h00;
      data_o = 8'h00;
   end
   task automatic set_sep(input logic v);
      @(posedge clk_sys_i) sep_o <= v;
   endtask
   // one access; a read holds its strobe until the answer is sampled at an edge or three edges pass without one
   // released lines show the inverse so stale values never pass
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      q = 8'hXX;
      @(posedge clk_sys_i);
      cs_n_o <= 1'b0;
      addr_o <= a;
      data_o <= d;
      if (sep_o) begin
         wr_n_o <= ~wr;
         rd_n_o <= wr;
      end else begin
         wr_n_o <= ~wr;
      end
      @(posedge clk_sys_i);
      for (int n = 0; n < 3 && !wr; n++) begin
         @(posedge clk_sys_i);
         if (rd_valid_i === 1'b1) begin
            q = rd_data_i;
            break;
         end
      end
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      addr_o <= ~a;
      data_o <= ~d;
   endtask
   // stray write strobe with chip select left high
   task automatic stray(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_n_o <= 1'b0;
      addr_o <= a;
      data_o <= d;
      @(posedge clk_sys_i) wr_n_o <= 1'b1;
   endtask
endmodule // ouhs_host_model

// File: verification/tb_top.sv
// self-checking bench for the uart host select glue
// assumes the host model owns the bus pins and the bench the rest
`timescale 1ns/1ps
module tb_top
   import ouhs_pkg::*;
;
   typedef struct packed { logic [2:0] ch; logic [7:0] d; logic [1:0] mo; } ouhs_row_t;
   logic                  clk_sys_i, reset_i, strap, tmr_ck, wake;
   logic                  sep, cs_n, rd_n, wr_n, rd_valid, int_o;
   logic [7:0]            addr, wdata, rd_data, q, txl, rxl;
   logic [7:0]            fctl [8];
   logic [7:0]            mctl [8];
   logic [7:0]            hctl [8];
   ouhs_modem_in_t [7:0]  min;
   ouhs_fifo_stat_t [7:0] fst;
   ouhs_modem_out_t [7:0] mout;
   int                    fails = 0;
   int                    n_checks = 0;
   int                    cyc = 0;
   // mcr writes per channel and the modem pins {rts_n, dtr_n} they give
   ouhs_row_t rows [8] = '{'{3'h0, 8'h01, 2'h2}, '{3'h1, 8'h02, 2'h1},
      '{3'h2, 8'h03, 2'h0}, '{3'h3, 8'h00, 2'h3}, '{3'h4, 8'h01, 2'h2},
      '{3'h5, 8'h02, 2'h1}, '{3'h6, 8'h03, 2'h0}, '{3'h7, 8'h40, 2'h3}};
   ouhs_host_select dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .bus_sep_strobes_i(sep), .cs_n_i(cs_n), .read_strobe_n_i(rd_n),
      .write_strobe_n_i(wr_n), .addr_i(addr), .wr_data_i(wdata),
      .infrared_start_strap_i(strap), .timer_ext_clock_in_i(tmr_ck),
      .sleep_wake_i(wake), .modem_in_i(min), .fifo_stat_i(fst),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .modem_out_o(mout),
      .fifo_ctl_o(fctl), .modem_ctl_o(mctl), .hdx_ctl_o(hctl),
      .tx_int_level_o(txl), .rx_int_level_o(rxl), .int_o(int_o));
   ouhs_host_model host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data),
      .rd_valid_i(rd_valid), .sep_o(sep), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .addr_o(addr), .data_o(wdata));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, q);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      host.acc(1'b0, a, 8'h00, q);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hang guard, far above the roughly 125 cycles the run needs
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      reset_i = 1'b1;
      strap = 1'b1;
      tmr_ck = 1'b0;
      wake = 1'b0;
      min = '1;
      fst = '0;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i) #1;
      chk("modem out", 16'(mout), 16'hFFFF);
      for (int k = 0; k < 8; k++) chk("ir bit", 16'(mctl[k][6]), 16'h0001);
      $display("test reset done");
      foreach (rows[i]) begin
         wr({1'b0, rows[i].ch, OUHS_CH_MCR_OFS}, rows[i].d);
         rd({1'b0, rows[i].ch, OUHS_CH_MCR_OFS});
         chk("mcr read", 16'(q), 16'(rows[i].d));
         chk("modem pins", 16'(mout[rows[i].ch]), 16'(rows[i].mo));
      end
      $display("test channel table done");
      wr(8'h8C, 8'h01);
      wr(8'h24, 8'h03);
      for (int k = 0; k < 8; k++) chk("bcast", 16'(mctl[k]), 16'h0003);
      wr(8'h8C, 8'h00);
      @(posedge clk_sys_i) strap <= 1'b0;
      wr(8'h8B, 8'h05);
      chk("soft ch0", 16'(mctl[0]), 16'h0000);
      chk("soft ch1", 16'(mctl[1]), 16'h0003);
      rd(8'h8B);
      chk("soft rd", 16'(q), 16'h0000);
      $display("test broadcast and soft reset done");
      @(posedge clk_sys_i) min[3] <= 4'b0101;
      rd(8'h36);
      chk("status", 16'(q), 16'h0009);
      rd(8'h8F);
      chk("unmapped", 16'(q), 16'h0000);
      @(posedge clk_sys_i) fst[0] <= 4'b1011;
      wr(8'h02, 8'h01);
      chk("fcr", 16'(fctl[0]), 16'h0001);
      chk("tx lvl", 16'(txl), 16'h0001);
      chk("rx lvl", 16'(rxl), 16'h0000);
      rd(8'h81);
      chk("src1", 16'(q), 16'h0001);
      wr(8'h08, 8'h01);
      chk("hdx", 16'(hctl[0]), 16'h0001);
      chk("tx hdx", 16'(txl), 16'h0000);
      @(posedge clk_sys_i) fst[0].rx_above_trig <= 1'b0;
      @(posedge clk_sys_i) wake <= 1'b1;
      #1;
      chk("rx low", 16'(rxl), 16'h0001);
      chk("int", 16'(int_o), 16'h0001);
      rd(8'h83);
      chk("src3", 16'(q), 16'h0002);
      $display("test interrupt levels done");
      wr(8'h88, 8'h03);
      repeat (3) begin
         @(posedge clk_sys_i) tmr_ck <= 1'b1;
         @(posedge clk_sys_i) tmr_ck <= 1'b0;
      end
      wr(8'h88, 8'h00);
      rd(8'h89);
      chk("tmr lo", 16'(q), 16'h0003);
      rd(8'h8A);
      chk("tmr hi", 16'(q), 16'h0000);
      // internal clock from all ones: the first tick wraps and raises the flag
      wr(8'h89, 8'hFF);
      wr(8'h8A, 8'hFF);
      wr(8'h88, 8'h01);
      rd(8'h83);
      chk("wrap flag", 16'(q), 16'h0003);
      rd(8'h83);
      chk("flag clr", 16'(q), 16'h0002);
      $display("test timer done");
      host.set_sep(1'b0);
      wr(8'h54, 8'h01);
      rd(8'h54);
      chk("single rd", 16'(q), 16'h0001);
      chk("single pins", 16'(mout[5]), 16'h0002);
      host.set_sep(1'b1);
      host.stray(8'h54, 8'h03);
      #1;
      chk("no cs", 16'(mctl[5]), 16'h0001);
      $display("test bus styles done");
      @(posedge clk_sys_i) reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk("rst pins", 16'(mout), 16'hFFFF);
      chk("rst mcr", 16'(mctl[5]), 16'h0000);
      reset_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      $display("test second reset done");
      print_verdict();
   end
endmodule // tb_top
bind ouhs_host_select ouhs_host_select_props u_props (.clk_sys_i(clk_sys_i),
   .reset_i(reset_i), .bus_sep_strobes_i(bus_sep_strobes_i), .cs_n_i(cs_n_i),
   .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .fifo_stat_i(fifo_stat_i),
   .infrared_start_strap_i(infrared_start_strap_i), .rd_valid_o(rd_valid_o),
   .modem_out_o(modem_out_o), .fifo_ctl_o(fifo_ctl_o), .modem_ctl_o(modem_ctl_o),
   .hdx_ctl_o(hdx_ctl_o), .tx_int_level_o(tx_int_level_o),
   .rx_int_level_o(rx_int_level_o), .int_o(int_o));
